/* File: rtl/rgd_pkg.sv */
// Purpose: Shared constants for the right-channel AGC debounce and gain status bank
// Assumes: Byte-wide register port, page already resolved by the control bus logic
// Notes:   Debounce lengths are counted in sample periods, not clock cycles
package rgd_pkg;

  // Register offsets
  localparam logic [6:0] RGD_ADDR_NOISE_DB  = 7'h63;
  localparam logic [6:0] RGD_ADDR_SIGNAL_DB = 7'h64;
  localparam logic [6:0] RGD_ADDR_GAIN      = 7'h65;
  localparam logic [6:0] RGD_ADDR_RSVD_LO   = 7'h66;
  localparam logic [6:0] RGD_ADDR_RSVD_HI   = 7'h7F;

  // Field widths, reset values and the noise threshold off code
  localparam int         RGD_NOISE_W     = 5;
  localparam int         RGD_SIGNAL_W    = 4;
  localparam logic [4:0] RGD_NOISE_RST   = 5'h00;
  localparam logic [3:0] RGD_SIGNAL_RST  = 4'h0;
  localparam logic [7:0] RGD_GAIN_RST    = 8'h00;
  localparam logic [4:0] RGD_THRESH_OFF  = 5'h00;

  // Gain code limits, two's complement in half-dB steps
  localparam logic signed [7:0] RGD_GAIN_MIN = 8'hE8;
  localparam logic signed [7:0] RGD_GAIN_MAX = 8'h50;

  // Debounce decode: nonzero codes up to the knee are powers of two, above it multiples of a unit
  localparam logic [4:0] RGD_NOISE_KNEE  = 5'h0A;
  localparam logic [3:0] RGD_SIGNAL_KNEE = 4'hA;
  localparam int         RGD_NOISE_UNIT  = 4096;
  localparam int         RGD_SIGNAL_UNIT = 2048;
  localparam int         RGD_CNT_W       = 17;

  typedef enum logic [0:0] {
    RGD_ST_SIGNAL = 1'b0,
    RGD_ST_NOISE  = 1'b1
  } rgd_state_t;

endpackage : rgd_pkg

/* File: rtl/rgd_bank.sv */
// Purpose: Right AGC noise/signal debounce registers, debounce engine and gain status
// Assumes: i_sample_tick pulses once per sample period; detector and gain inputs are
//          produced by logic on i_clk
// Notes:   Reserved space reads zero; writes there are dropped
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Five-bit noise debounce code selects sample count
// - Four-bit signal debounce code selects sample count
// - Report applied gain, signed half-dB code
// - Gain status reads zero after reset
// - Never report codes above plus forty dB
// - AGC works only while enabled
// - Zero noise threshold disables noise detection
module rgd_bank
  import rgd_pkg::*;
#(
  // Run counter width; it must reach the longest debounce length in samples
  parameter int CNT_W = RGD_CNT_W
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // Register port
  input  wire logic        i_wr_en,
  input  wire logic [6:0]  i_addr,
  input  wire logic [7:0]  i_wr_data,
  output logic      [7:0]  o_rd_data,
  // Neighbouring AGC settings
  input  wire logic        i_agc_en,
  input  wire logic [4:0]  i_noise_thresh,
  // AGC core
  input  wire logic        i_sample_tick,
  input  wire logic        i_below_thresh,
  input  wire logic        i_gain_valid,
  input  wire logic [7:0]  i_gain_req,
  // Status
  output logic             o_noise_state,
  output logic [7:0]       o_gain_applied
);

  // Longest runs the two fields can ask for
  localparam int MAX_NOISE_LEN  = ((1 << RGD_NOISE_W) - 1 - int'(RGD_NOISE_KNEE))
                                  * RGD_NOISE_UNIT;
  localparam int MAX_SIGNAL_LEN = ((1 << RGD_SIGNAL_W) - 1 - int'(RGD_SIGNAL_KNEE))
                                  * RGD_SIGNAL_UNIT;
  localparam int MAX_LEN        = (MAX_NOISE_LEN > MAX_SIGNAL_LEN) ? MAX_NOISE_LEN
                                                                   : MAX_SIGNAL_LEN;

  // A narrow counter would wrap before the run ends and never flip the state
  if (CNT_W < $clog2(MAX_LEN + 1) || CNT_W > 31) begin : g_bad_cnt_w
    $error("rgd_bank: CNT_W cannot hold the longest debounce run");
  end

  // Configuration fields
  logic [RGD_NOISE_W-1:0]  noise_db_q;
  logic [RGD_SIGNAL_W-1:0] signal_db_q;
  logic                    wr_noise;
  logic                    wr_signal;

  // Gain status
  logic [7:0]              gain_q;
  logic [7:0]              gain_d;
  logic                    gain_take;

  // Debounce engine
  logic [CNT_W-1:0]        cnt_q;
  logic [CNT_W-1:0]        cnt_d;
  rgd_state_t              state_q;
  rgd_state_t              state_d;
  logic [CNT_W-1:0]        noise_len;
  logic [CNT_W-1:0]        signal_len;
  logic [CNT_W-1:0]        target_len;
  logic                    det_active;
  logic                    want_flip;

  // Short codes double the length, long codes add a whole unit per step
  function automatic logic [CNT_W-1:0] noise_samples(input logic [4:0] code);
    if (code == 5'h00) begin
      noise_samples = '0;
    end else if (code <= RGD_NOISE_KNEE) begin
      noise_samples = CNT_W'(2) << code;
    end else begin
      noise_samples = CNT_W'(int'(code - RGD_NOISE_KNEE) * RGD_NOISE_UNIT);
    end
  endfunction : noise_samples

  function automatic logic [CNT_W-1:0] signal_samples(input logic [3:0] code);
    if (code == 4'h0) begin
      signal_samples = '0;
    end else if (code <= RGD_SIGNAL_KNEE) begin
      signal_samples = CNT_W'(2) << code;
    end else begin
      signal_samples = CNT_W'(int'(code - RGD_SIGNAL_KNEE) * RGD_SIGNAL_UNIT);
    end
  endfunction : signal_samples

  // Requests outside the documented range are pinned to its ends
  function automatic logic [7:0] clamp_gain(input logic [7:0] req);
    if ($signed(req) > RGD_GAIN_MAX) begin
      clamp_gain = RGD_GAIN_MAX;
    end else if ($signed(req) < RGD_GAIN_MIN) begin
      clamp_gain = RGD_GAIN_MIN;
    end else begin
      clamp_gain = req;
    end
  endfunction : clamp_gain

  // Write decode; the gain register and reserved space take no writes
  assign wr_noise  = i_wr_en && (i_addr == RGD_ADDR_NOISE_DB);
  assign wr_signal = i_wr_en && (i_addr == RGD_ADDR_SIGNAL_DB);

  // Configuration registers; only the documented field bits are stored
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      noise_db_q <= RGD_NOISE_RST;
    end else if (wr_noise) begin
      noise_db_q <= i_wr_data[RGD_NOISE_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      signal_db_q <= RGD_SIGNAL_RST;
    end else if (wr_signal) begin
      signal_db_q <= i_wr_data[RGD_SIGNAL_W-1:0];
    end
  end

  // Read mux; reserved bits and reserved space read zero, gain is read only
  always_comb begin
    case (i_addr)
      RGD_ADDR_NOISE_DB:  o_rd_data = {3'h0, noise_db_q};
      RGD_ADDR_SIGNAL_DB: o_rd_data = {4'h0, signal_db_q};
      RGD_ADDR_GAIN:      o_rd_data = gain_q;
      default:            o_rd_data = 8'h00;
    endcase
  end

  // Debounce lengths in samples
  assign noise_len  = noise_samples(noise_db_q);
  assign signal_len = signal_samples(signal_db_q);

  // Detection runs only with the AGC on and a nonzero noise threshold
  assign det_active = i_agc_en && (i_noise_thresh != RGD_THRESH_OFF);

  // The condition that would move us out of the present state
  assign want_flip  = (state_q == RGD_ST_SIGNAL) ? i_below_thresh : !i_below_thresh;
  assign target_len = (state_q == RGD_ST_SIGNAL) ? noise_len : signal_len;

  // Debounce: the opposite condition must hold for target_len + 1 consecutive samples.
  // A break in the run restarts the count, so short bursts never flip the state.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (!det_active) begin
      state_d = RGD_ST_SIGNAL;
      cnt_d   = '0;
    end else if (i_sample_tick) begin
      case (state_q)
        RGD_ST_SIGNAL, RGD_ST_NOISE: begin
          if (!want_flip) begin
            cnt_d = '0;
          end else if (cnt_q >= target_len) begin
            state_d = (state_q == RGD_ST_SIGNAL) ? RGD_ST_NOISE : RGD_ST_SIGNAL;
            cnt_d   = '0;
          end else begin
            cnt_d = cnt_q + CNT_W'(1);
          end
        end
        default: begin
          state_d = RGD_ST_SIGNAL;
          cnt_d   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= RGD_ST_SIGNAL;
    end else begin
      state_q <= state_d;
    end
  end

  // The counter only increments while below target_len, so it cannot wrap
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Gain status; held while disabled or in silence so noise is not pumped up
  assign gain_take = i_agc_en && i_gain_valid && (state_q == RGD_ST_SIGNAL);
  assign gain_d    = gain_take ? clamp_gain(i_gain_req) : gain_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      gain_q <= RGD_GAIN_RST;
    end else begin
      gain_q <= gain_d;
    end
  end

  // Status outputs come straight from the state and gain flip-flops
  assign o_noise_state  = (state_q == RGD_ST_NOISE);
  assign o_gain_applied = gain_q;

endmodule : rgd_bank

`default_nettype wire

/* File: verification/rgd_checker.sv */
// Purpose: Port checks for rgd_bank
// Assumes: One clock, synchronous reset
// Notes:   Attached by the bind below
`timescale 1ns/1ps
`default_nettype none
module rgd_checker (
  // Ports of rgd_bank, grouped to save space
  input wire logic       i_clk, i_srst, i_wr_en, i_agc_en, i_sample_tick,
  input wire logic       i_below_thresh, i_gain_valid, o_noise_state,
  input wire logic [6:0] i_addr,
  input wire logic [4:0] i_noise_thresh,
  input wire logic [7:0] i_wr_data, i_gain_req, o_rd_data, o_gain_applied
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_wr; i_wr_en && i_addr == 7'h63 ##1 i_addr == 7'h63; endsequence
  property p_wr; s_wr |-> o_rd_data == {3'h0, $past(i_wr_data[4:0])}; endproperty
  a_wr: assert property (p_wr) else $error("noise readback");
  property p_rd; i_addr == 7'h65 |-> o_rd_data == o_gain_applied; endproperty
  a_rd: assert property (p_rd) else $error("gain readback");
  property p_rsv; i_addr >= 7'h66 |-> o_rd_data == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read");
  property p_rng; $signed(o_gain_applied) <= 8'sh50 && $signed(o_gain_applied) >= -8'sd24;
  endproperty
  a_rng: assert property (p_rng) else $error("gain out of range");
  property p_upd; i_gain_valid && i_agc_en && !o_noise_state && $signed(i_gain_req) <= 8'sh50
    && $signed(i_gain_req) >= -8'sd24 |=> o_gain_applied == $past(i_gain_req); endproperty
  a_upd: assert property (p_upd) else $error("gain update");
  property p_hold; !i_agc_en |=> $stable(o_gain_applied); endproperty
  a_hold: assert property (p_hold) else $error("gain moved while off");
  property p_off; !i_agc_en || i_noise_thresh == 5'h00 |=> !o_noise_state; endproperty
  a_off: assert property (p_off) else $error("noise state while off");
  property p_flip; $rose(o_noise_state) |-> $past(i_sample_tick) && $past(i_below_thresh);
  endproperty
  a_flip: assert property (p_flip) else $error("noise flip without tick");
  property p_rst; disable iff (1'b0) i_srst |=> o_gain_applied == 8'h00 && !o_noise_state;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
endmodule : rgd_checker
bind rgd_bank rgd_checker chk_u (.*);
`default_nettype wire

/* File: verification/tb_rgd_bank.sv */
// Purpose: Self-checking bench for rgd_bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   A watcher compares reads against a queue of notes
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb_rgd_bank;
  logic i_clk = 0, i_srst = 1, i_wr_en = 0, i_agc_en = 0, i_sample_tick = 0;
  logic i_below_thresh = 0, i_gain_valid = 0, o_noise_state, look = 0;
  logic [6:0] i_addr = 0;
  logic [4:0] i_noise_thresh = 0;
  logic [7:0] i_wr_data = 0, i_gain_req = 0, o_rd_data, o_gain_applied, d;
  logic [9:0] q[$], n;
  logic [31:0] s = 32'hF498;
  int failures = 0, checks_done = 0;
  rgd_bank dut_u (.*);
  initial forever #10 i_clk = ~i_clk;
  function logic [7:0] rnd();
    s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s[7:0];
  endfunction : rnd
  task cyc(int k = 1); repeat (k) @(posedge i_clk); #1; endtask : cyc
  task note(logic [9:0] v); q.push_back(v); look = 1; cyc(); look = 0; endtask : note
  task rd(logic [6:0] a, logic [7:0] e); i_addr = a; note({2'b00, e}); endtask : rd
  task wr(logic [6:0] a, logic [7:0] v);
    i_addr = a; i_wr_data = v; i_wr_en = 1; cyc(); i_wr_en = 0;
  endtask : wr
  task gn(logic [7:0] v); i_gain_req = v; i_gain_valid = 1; cyc(); i_gain_valid = 0; endtask : gn
  task tk(logic b, int k);
    repeat (k) begin i_sample_tick = 1; i_below_thresh = b; cyc(); end
    i_sample_tick = 0;
  endtask : tk
  // Reads settle combinationally, so the falling edge is a safe sampling point
  always @(negedge i_clk) if (look) begin
    n = q.pop_front();
    case (n[9:8])
      2'd1: `CHK({7'h00, o_noise_state}, n[7:0])
      2'd2: `CHK(o_gain_applied, n[7:0])
      default: `CHK(o_rd_data, n[7:0])
    endcase
  end
  task conclude();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin #100000; failures++; conclude(); end
  initial begin
    cyc(4); i_srst = 0;
    rd(7'h65, 8'h00);
    d = rnd(); wr(7'h63, d); rd(7'h63, {3'h0, d[4:0]});
    d = rnd(); wr(7'h64, d); rd(7'h64, {4'h0, d[3:0]});
    wr(7'h65, 8'h11); rd(7'h65, 8'h00);
    wr(7'h70, 8'hFF); rd(7'h70, 8'h00);
    i_agc_en = 1; i_noise_thresh = 5'h01;
    gn(8'h60); rd(7'h65, 8'h50); note(10'h250);
    gn(8'hE0); rd(7'h65, 8'hE8);
    d = rnd() & 8'h3F; gn(d); rd(7'h65, d);
    wr(7'h63, 8'h01); tk(1, 4); note(10'h100);
    tk(1, 1); note(10'h101);
    gn(8'h20); rd(7'h65, d); note({2'd2, d});
    wr(7'h64, 8'h00); tk(0, 1); note(10'h100);
    tk(1, 5); note(10'h101);
    i_noise_thresh = 5'h00; cyc(); note(10'h100);
    i_agc_en = 0; gn(8'h08); rd(7'h65, d);
    conclude();
  end
endmodule : tb_rgd_bank
`default_nettype wire
